// File: verilog/isp_pkg.sv
// constants and types shared by both ends of the serial register port
package isp_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLK_KHZ = 100000;
  localparam logic [6:0] DEF_TARGET_ADDR = 7'h1E;
  localparam logic [2:0] PINSEL_GLOBAL_DVS = 3'h4;
  localparam logic [2:0] PINSEL_DVS_B12 = 3'h6;
  localparam logic [2:0] PINSEL_DVS_B123 = 3'h7;
  localparam int SPIKE_FAST_NS = 50;
  localparam int SPIKE_HS_NS = 10;
  localparam int FILT_LONG_CYC = (SPIKE_FAST_NS / CLK_PERIOD_NS < 1) ? 1 :
                                 SPIKE_FAST_NS / CLK_PERIOD_NS;
  localparam int FILT_SHORT_CYC = (SPIKE_HS_NS / CLK_PERIOD_NS < 1) ? 1 :
                                  SPIKE_HS_NS / CLK_PERIOD_NS;
  localparam logic [2:0] FILT_LONG_LIM = 3'(FILT_LONG_CYC);
  localparam logic [2:0] FILT_SHORT_LIM = 3'(FILT_SHORT_CYC);
  localparam int SCL_KHZ = 400;
  localparam int QTR_CYC = (CLK_KHZ + 4 * SCL_KHZ - 1) / (4 * SCL_KHZ);
  localparam logic [6:0] QTR_LAST = 7'(QTR_CYC - 1);
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [1:0] PH_ADDR = 2'h0;
  localparam logic [1:0] PH_REG = 2'h1;
  localparam logic [1:0] PH_DATA = 2'h2;
  localparam logic [2:0] R_ADDRW = 3'h0;
  localparam logic [2:0] R_REG = 3'h1;
  localparam logic [2:0] R_WDATA = 3'h2;
  localparam logic [2:0] R_ADDRR = 3'h3;
  localparam logic [2:0] R_RDATA = 3'h4;
  typedef enum logic [4:0] {
    DS_IDLE = 5'h01,
    DS_RX = 5'h02,
    DS_ACK = 5'h04,
    DS_TX = 5'h08,
    DS_RACK = 5'h10
  } isp_dev_state_t;
  typedef enum logic [3:0] {
    HS_IDLE = 4'h1,
    HS_START = 4'h2,
    HS_BIT = 4'h4,
    HS_STOP = 4'h8
  } isp_host_state_t;
endpackage

// File: verilog/isp_bus_if.sv
// two-wire bus between master and target, open-drain wired-and
`timescale 1ns/10ps
interface isp_bus_if;
  logic hostSclO;
  logic hostSclOe_n;
  logic hostSdaO;
  logic hostSdaOe_n;
  logic devSdaO;
  logic devSdaOe_n;
  logic scl;
  logic sda;
  // released lines float high through the pull-up
  assign scl = hostSclOe_n | hostSclO;
  assign sda = (hostSdaOe_n | hostSdaO) & (devSdaOe_n | devSdaO);
  modport device (input scl, input sda, output devSdaO, output devSdaOe_n);
  modport host (input scl, input sda, output hostSclO, output hostSclOe_n,
                output hostSdaO, output hostSdaOe_n);
endinterface

// File: verilog/isp_sync_filter.sv
// three-stage synchroniser with spike filter for one bus line
`timescale 1ns/10ps
module isp_sync_filter (
  input logic clk,
  input logic arst_n,
  input logic din,
  input logic hsMode,
  output logic dout
);
  logic s1Ff;
  logic s2Ff;
  logic s3Ff;
  logic outFf;
  logic [2:0] cntFf;
  wire [2:0] lim = hsMode ? isp_pkg::FILT_SHORT_LIM : isp_pkg::FILT_LONG_LIM;
  wire moving = (s2Ff == s3Ff) && (s3Ff != outFf);
  // a level must outlast the spike width before it is believed
  wire settle = moving && (cntFf == lim);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1Ff <= 1'b1;
      s2Ff <= 1'b1;
      s3Ff <= 1'b1;
      outFf <= 1'b1;
      cntFf <= 3'h0;
    end else begin
      s1Ff <= din;
      s2Ff <= s1Ff;
      s3Ff <= s2Ff;
      cntFf <= (moving && !settle) ? cntFf + 3'h1 : 3'h0;
      if (settle) begin
        outFf <= s3Ff;
      end
    end
  end
  assign dout = outFf;
endmodule

// File: verilog/isp_target_port.sv
// serial target port into the 256-byte register space
`timescale 1ns/10ps
module isp_target_port (
  input logic clk,
  input logic arst_n,
  isp_bus_if.device bus,
  input logic otpLoad,
  input logic [6:0] otpAddr,
  input logic [2:0] pinFuncSel,
  input logic hsMode,
  input logic [7:0] regRdAddr,
  output logic [7:0] regRdData,
  output logic regWrStb,
  output logic [7:0] regWrAddr,
  output logic [7:0] regWrData,
  output logic busActive
);
  isp_pkg::isp_dev_state_t stateFf;
  isp_pkg::isp_dev_state_t nxtState;
  logic [3:0] bitFf;
  logic [3:0] nxtBit;
  logic [7:0] shiftFf;
  logic [7:0] nxtShift;
  logic [1:0] phaseFf;
  logic [1:0] nxtPhase;
  logic rwFf;
  logic nxtRw;
  logic [7:0] ptrFf;
  logic [7:0] nxtPtr;
  logic relFf;
  logic nxtRel;
  logic mAckFf;
  logic nxtMAck;
  logic memWe;
  logic [6:0] ownAddrFf;
  logic sclQ;
  logic sdaQ;
  logic sclPrevFf;
  logic sdaPrevFf;
  logic regWrStbFf;
  logic [7:0] regWrAddrFf;
  logic [7:0] regWrDataFf;
  logic [7:0] regRdDataFf;
  logic busActiveFf;
  logic [7:0] regMem [256];

  isp_sync_filter u_scl_filt (
    .clk(clk),
    .arst_n(arst_n),
    .din(bus.scl),
    .hsMode(hsMode),
    .dout(sclQ)
  );
  isp_sync_filter u_sda_filt (
    .clk(clk),
    .arst_n(arst_n),
    .din(bus.sda),
    .hsMode(hsMode),
    .dout(sdaQ)
  );

  // the port is alive only in pin modes that route the bus to the IOs
  wire busOnPins = (pinFuncSel == isp_pkg::PINSEL_GLOBAL_DVS) ||
                   (pinFuncSel == isp_pkg::PINSEL_DVS_B12) ||
                   (pinFuncSel == isp_pkg::PINSEL_DVS_B123);
  wire sclRise = sclQ & ~sclPrevFf;
  wire sclFall = ~sclQ & sclPrevFf;
  wire sclHigh = sclQ & sclPrevFf;
  wire startSeen = sclHigh & ~sdaQ & sdaPrevFf;
  wire stopSeen = sclHigh & sdaQ & ~sdaPrevFf;
  wire addrHit = (shiftFf[7:1] == ownAddrFf);
  wire byteIn = (bitFf == isp_pkg::BYTE_BITS);
  wire [7:0] memRd = regMem[ptrFf];

  always_comb begin
    nxtState = stateFf;
    nxtBit = bitFf;
    nxtShift = shiftFf;
    nxtPhase = phaseFf;
    nxtRw = rwFf;
    nxtPtr = ptrFf;
    nxtRel = relFf;
    nxtMAck = mAckFf;
    memWe = 1'b0;
    if (!busOnPins || stopSeen) begin
      nxtState = isp_pkg::DS_IDLE;
      nxtRel = 1'b1;
    end else if (startSeen) begin
      nxtState = isp_pkg::DS_RX;
      nxtPhase = isp_pkg::PH_ADDR;
      nxtBit = 4'h0;
      nxtRel = 1'b1;
    end else begin
      unique case (stateFf)
        isp_pkg::DS_IDLE: begin
          nxtRel = 1'b1;
        end
        isp_pkg::DS_RX: begin
          if (sclRise) begin
            nxtShift = {shiftFf[6:0], sdaQ};
            nxtBit = bitFf + 4'h1;
          end else if (sclFall && byteIn) begin
            nxtState = isp_pkg::DS_ACK;
            nxtRel = 1'b0;
            unique case (phaseFf)
              isp_pkg::PH_ADDR: begin
                nxtRw = shiftFf[0];
                if (!addrHit) begin
                  nxtState = isp_pkg::DS_IDLE;
                  nxtRel = 1'b1;
                end
              end
              isp_pkg::PH_REG: begin
                nxtPtr = shiftFf;
              end
              default: begin
                // only a whole byte is ever stored
                memWe = 1'b1;
                nxtPtr = ptrFf + 8'h01;
              end
            endcase
          end
        end
        isp_pkg::DS_ACK: begin
          if (sclFall) begin
            nxtBit = 4'h0;
            if (phaseFf == isp_pkg::PH_ADDR && rwFf) begin
              nxtState = isp_pkg::DS_TX;
              nxtShift = memRd;
              nxtRel = memRd[7];
            end else begin
              nxtState = isp_pkg::DS_RX;
              nxtRel = 1'b1;
              nxtPhase = (phaseFf == isp_pkg::PH_ADDR) ? isp_pkg::PH_REG :
                         isp_pkg::PH_DATA;
            end
          end
        end
        isp_pkg::DS_TX: begin
          if (sclRise) begin
            nxtBit = bitFf + 4'h1;
          end else if (sclFall && byteIn) begin
            nxtState = isp_pkg::DS_RACK;
            nxtRel = 1'b1;
            nxtPtr = ptrFf + 8'h01;
            nxtBit = 4'h0;
          end else if (sclFall) begin
            // new bit only after the clock has gone low
            nxtShift = {shiftFf[6:0], 1'b0};
            nxtRel = shiftFf[6];
          end
        end
        isp_pkg::DS_RACK: begin
          if (sclRise) begin
            nxtMAck = ~sdaQ;
          end else if (sclFall && mAckFf) begin
            nxtState = isp_pkg::DS_TX;
            nxtShift = memRd;
            nxtRel = memRd[7];
          end else if (sclFall) begin
            nxtState = isp_pkg::DS_IDLE;
            nxtRel = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stateFf <= isp_pkg::DS_IDLE;
      bitFf <= 4'h0;
      shiftFf <= 8'h00;
      phaseFf <= isp_pkg::PH_ADDR;
      rwFf <= 1'b0;
      ptrFf <= 8'h00;
      relFf <= 1'b1;
      mAckFf <= 1'b0;
      sclPrevFf <= 1'b1;
      sdaPrevFf <= 1'b1;
    end else begin
      stateFf <= nxtState;
      bitFf <= nxtBit;
      shiftFf <= nxtShift;
      phaseFf <= nxtPhase;
      rwFf <= nxtRw;
      ptrFf <= nxtPtr;
      relFf <= nxtRel;
      mAckFf <= nxtMAck;
      sclPrevFf <= sclQ;
      sdaPrevFf <= sdaQ;
    end
  end

  // address comes up at the default and is replaced once the OTP is read
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ownAddrFf <= isp_pkg::DEF_TARGET_ADDR;
    end else if (otpLoad) begin
      ownAddrFf <= otpAddr;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      regWrStbFf <= 1'b0;
      regWrAddrFf <= 8'h00;
      regWrDataFf <= 8'h00;
      regRdDataFf <= 8'h00;
      busActiveFf <= 1'b0;
    end else begin
      regWrStbFf <= memWe;
      regWrAddrFf <= ptrFf;
      regWrDataFf <= shiftFf;
      regRdDataFf <= regMem[regRdAddr];
      busActiveFf <= (stateFf != isp_pkg::DS_IDLE);
    end
  end

  // storage is data, not control, so it carries no reset
  always_ff @(posedge clk) begin
    if (memWe) begin
      regMem[ptrFf] <= shiftFf;
    end
  end

  // open drain: the pin is only ever pulled low, never driven high
  assign bus.devSdaO = 1'b0;
  assign bus.devSdaOe_n = relFf;
  assign regRdData = regRdDataFf;
  assign regWrStb = regWrStbFf;
  assign regWrAddr = regWrAddrFf;
  assign regWrData = regWrDataFf;
  assign busActive = busActiveFf;
endmodule

// File: verilog/isp_bus_master.sv
// bus master end: register writes and reads to one target
`timescale 1ns/10ps
module isp_bus_master (
  input logic clk,
  input logic arst_n,
  isp_bus_if.host bus,
  input logic cmdValid,
  output logic cmdReady,
  input logic cmdRead,
  input logic [6:0] cmdTarget,
  input logic [7:0] cmdReg,
  input logic [7:0] cmdLen,
  input logic [7:0] wrByte,
  output logic wrTaken,
  output logic rdValid,
  output logic [7:0] rdByte,
  output logic done,
  output logic nackSeen
);
  isp_pkg::isp_host_state_t stateFf;
  isp_pkg::isp_host_state_t nxtState;
  logic [6:0] qCntFf;
  logic [1:0] qFf;
  logic [1:0] nxtQ;
  logic [3:0] bitFf;
  logic [3:0] nxtBit;
  logic [2:0] roleFf;
  logic [2:0] nxtRole;
  logic [7:0] txFf;
  logic [7:0] nxtTx;
  logic [7:0] rxFf;
  logic [7:0] nxtRx;
  logic [7:0] lenFf;
  logic [7:0] nxtLen;
  logic readFf;
  logic nxtRead;
  logic [6:0] targetFf;
  logic [6:0] nxtTarget;
  logic [7:0] regFf;
  logic [7:0] nxtReg;
  logic sclRelFf;
  logic nxtSclRel;
  logic sdaRelFf;
  logic nxtSdaRel;
  logic badFf;
  logic nxtBad;
  logic nackFf;
  logic nxtNack;
  logic wrTakenFf;
  logic rdValidFf;
  logic doneFf;
  logic cmdReadyFf;
  logic sdaQ;

  isp_sync_filter u_sda_filt (
    .clk(clk),
    .arst_n(arst_n),
    .din(bus.sda),
    .hsMode(1'b0),
    .dout(sdaQ)
  );

  wire tick = (qCntFf == isp_pkg::QTR_LAST);
  wire ackSlot = (bitFf == isp_pkg::BYTE_BITS);
  wire roleRx = (roleFf == isp_pkg::R_RDATA);
  wire lastByte = (lenFf == 8'h01);
  wire finish = badFf || lastByte;

  always_comb begin
    nxtState = stateFf;
    nxtQ = qFf;
    nxtBit = bitFf;
    nxtRole = roleFf;
    nxtTx = txFf;
    nxtRx = rxFf;
    nxtLen = lenFf;
    nxtRead = readFf;
    nxtTarget = targetFf;
    nxtReg = regFf;
    nxtSclRel = sclRelFf;
    nxtSdaRel = sdaRelFf;
    nxtBad = badFf;
    nxtNack = nackFf;
    unique case (stateFf)
      isp_pkg::HS_IDLE: begin
        if (cmdValid) begin
          nxtState = isp_pkg::HS_START;
          nxtQ = 2'h0;
          nxtRole = isp_pkg::R_ADDRW;
          nxtTx = {cmdTarget, 1'b0};
          nxtTarget = cmdTarget;
          nxtReg = cmdReg;
          nxtRead = cmdRead;
          nxtLen = (cmdLen == 8'h00) ? 8'h01 : cmdLen;
          nxtNack = 1'b0;
        end
      end
      isp_pkg::HS_START: begin
        if (tick) begin
          nxtQ = qFf + 2'h1;
          unique case (qFf)
            2'h0: nxtSdaRel = 1'b1;
            2'h1: nxtSclRel = 1'b1;
            2'h2: nxtSdaRel = 1'b0;
            default: begin
              nxtSclRel = 1'b0;
              nxtState = isp_pkg::HS_BIT;
              nxtBit = 4'h0;
            end
          endcase
        end
      end
      isp_pkg::HS_BIT: begin
        if (tick) begin
          nxtQ = qFf + 2'h1;
          unique case (qFf)
            2'h0: begin
              // data set while clock low; ack low only on read bytes before the last, else released
              if (ackSlot) begin
                nxtSdaRel = roleRx ? lastByte : 1'b1;
              end else begin
                nxtSdaRel = roleRx ? 1'b1 : txFf[7];
              end
            end
            2'h1: nxtSclRel = 1'b1;
            2'h2: begin
              if (ackSlot) begin
                nxtBad = !roleRx && sdaQ;
              end else begin
                nxtRx = {rxFf[6:0], sdaQ};
              end
            end
            default: begin
              nxtSclRel = 1'b0;
              nxtBit = ackSlot ? 4'h0 : bitFf + 4'h1;
              nxtTx = {txFf[6:0], 1'b0};
              if (ackSlot) begin
                unique case (roleFf)
                  isp_pkg::R_ADDRW: begin
                    nxtRole = isp_pkg::R_REG;
                    nxtTx = regFf;
                  end
                  isp_pkg::R_REG: begin
                    nxtRole = readFf ? isp_pkg::R_ADDRR : isp_pkg::R_WDATA;
                    nxtTx = readFf ? {targetFf, 1'b1} : wrByte;
                  end
                  isp_pkg::R_ADDRR: begin
                    nxtRole = isp_pkg::R_RDATA;
                  end
                  default: begin
                    nxtLen = lenFf - 8'h01;
                    nxtTx = wrByte;
                  end
                endcase
                if (roleFf == isp_pkg::R_REG && readFf && !badFf) begin
                  nxtState = isp_pkg::HS_START;
                end
                // stop only on a byte boundary, after its ack slot
                if (badFf || (roleFf >= isp_pkg::R_WDATA &&
                              roleFf != isp_pkg::R_ADDRR && lastByte)) begin
                  nxtState = isp_pkg::HS_STOP;
                  nxtNack = badFf;
                end
              end
            end
          endcase
        end
      end
      isp_pkg::HS_STOP: begin
        if (tick) begin
          nxtQ = qFf + 2'h1;
          unique case (qFf)
            2'h0: nxtSdaRel = 1'b0;
            2'h1: nxtSclRel = 1'b1;
            2'h2: nxtSdaRel = 1'b1;
            default: nxtState = isp_pkg::HS_IDLE;
          endcase
        end
      end
    endcase
  end

  wire byteEnd = (stateFf == isp_pkg::HS_BIT) && tick && (qFf == 2'h3) &&
                 ackSlot;
  wire takeWr = byteEnd && !finish &&
                ((roleFf == isp_pkg::R_REG && !readFf) ||
                 roleFf == isp_pkg::R_WDATA);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stateFf <= isp_pkg::HS_IDLE;
      qCntFf <= 7'h00;
      qFf <= 2'h0;
      bitFf <= 4'h0;
      roleFf <= isp_pkg::R_ADDRW;
      txFf <= 8'h00;
      rxFf <= 8'h00;
      lenFf <= 8'h00;
      readFf <= 1'b0;
      targetFf <= 7'h00;
      regFf <= 8'h00;
      sclRelFf <= 1'b1;
      sdaRelFf <= 1'b1;
      badFf <= 1'b0;
      nackFf <= 1'b0;
      wrTakenFf <= 1'b0;
      rdValidFf <= 1'b0;
      doneFf <= 1'b0;
      cmdReadyFf <= 1'b0;
    end else begin
      stateFf <= nxtState;
      qCntFf <= tick ? 7'h00 : qCntFf + 7'h01;
      qFf <= nxtQ;
      bitFf <= nxtBit;
      roleFf <= nxtRole;
      txFf <= nxtTx;
      rxFf <= nxtRx;
      lenFf <= nxtLen;
      readFf <= nxtRead;
      targetFf <= nxtTarget;
      regFf <= nxtReg;
      sclRelFf <= nxtSclRel;
      sdaRelFf <= nxtSdaRel;
      badFf <= nxtBad;
      nackFf <= nxtNack;
      wrTakenFf <= takeWr;
      rdValidFf <= byteEnd && roleRx;
      doneFf <= (stateFf == isp_pkg::HS_STOP) &&
                (nxtState == isp_pkg::HS_IDLE);
      cmdReadyFf <= (nxtState == isp_pkg::HS_IDLE);
    end
  end

  assign bus.hostSclO = 1'b0;
  assign bus.hostSclOe_n = sclRelFf;
  assign bus.hostSdaO = 1'b0;
  assign bus.hostSdaOe_n = sdaRelFf;
  assign cmdReady = cmdReadyFf;
  assign wrTaken = wrTakenFf;
  assign rdValid = rdValidFf;
  assign rdByte = rxFf;
  assign done = doneFf;
  assign nackSeen = nackFf;
endmodule

// File: dv/isp_bus_properties.sv
// assertions on the two-wire bus joining master and target
`timescale 1ns/10ps
module isp_bus_properties (
  input logic clk,
  input logic arst_n,
  input logic hostSclO,
  input logic hostSclOe_n,
  input logic hostSdaO,
  input logic hostSdaOe_n,
  input logic devSdaO,
  input logic devSdaOe_n,
  input logic scl,
  input logic sda
);
  logic seenStart_ff;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // any sda move with scl high is a start (sda low) or a stop (sda high)
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      seenStart_ff <= 1'h0;
    end else if (scl && $changed(sda)) begin
      seenStart_ff <= !sda;
    end
  end
  sequence sStart;
    scl && $fell(sda);
  endsequence
  sequence sStop;
    scl && $rose(sda);
  endsequence
  property pDevHold;
    $fell(scl) |-> $stable(devSdaOe_n) [*3];
  endproperty
  property pOneDriver;
    $rose(scl) |-> hostSdaOe_n || devSdaOe_n;
  endproperty
  property pBitStands;
    $fell(devSdaOe_n) |-> !devSdaOe_n [*8];
  endproperty
  AST_OPEN_DRAIN: assert property (!(devSdaO | hostSdaO | hostSclO))
    else $error("bus pin driven high");
  AST_DEV_SCL_LOW: assert property ($changed(devSdaOe_n) |-> !scl)
    else $error("target moved sda while scl high");
  // target reacts through its filter, so its bit outlives the scl fall
  AST_DEV_HOLD: assert property (pDevHold)
    else $error("target sda hold too short");
  AST_ONE_DRIVER: assert property (pOneDriver)
    else $error("both ends pull sda at scl rise");
  AST_NO_EARLY_DRIVE: assert property (!seenStart_ff |-> devSdaOe_n)
    else $error("target drives sda outside a frame");
  AST_START_HOLD: assert property (sStart |-> scl [*8])
    else $error("scl fell right after start");
  AST_STOP_IDLE: assert property (sStop |-> (scl && sda) [*8])
    else $error("bus not idle after stop");
  AST_DEV_BIT_STANDS: assert property (pBitStands)
    else $error("target low pulse too short");
endmodule

// File: dv/i2c_slave_register_port_tb.sv
// bench joining master and target, plus a bit-banged second target
`timescale 1ns/10ps
module i2c_slave_register_port_tb;
  logic clk = 1'h0;
  logic arst_n = 1'h0;
  logic otpLoad = 1'h0;
  logic [6:0] otpAddr = isp_pkg::DEF_TARGET_ADDR;
  logic [2:0] pinFuncSel = 3'h4;
  logic hsMode = 1'h0;
  logic [7:0] regRdAddr = 8'h00;
  logic [7:0] regRdData, regWrAddr, regWrData, rdByte, wAddrB, wDataB;
  logic regWrStb, busActive, cmdReady, wrTaken, rdValid, done, nackSeen;
  logic stbB, ackB;
  logic actSeen = 1'h0;
  logic cmdValid = 1'h0;
  logic cmdRead = 1'h0;
  logic [6:0] cmdTarget = 7'h00;
  logic [7:0] cmdReg = 8'h00;
  logic [7:0] cmdLen = 8'h00;
  logic [7:0] wrBuf [4] = '{default: 8'h00};
  logic [7:0] wrByte;
  logic [8:0] shf = 9'h000;
  logic [8:0] wireQ [$];
  logic [8:0] expQ [$];
  logic [15:0] wrQ [$];
  logic [15:0] wrQB [$];
  logic [7:0] rdQ [$];
  int wrIdx = 0;
  int nb = 0;
  int fails = 0;
  int n_tests = 0;
  isp_bus_if bus ();
  isp_bus_if bus2 ();
  assign wrByte = wrBuf[wrIdx[1:0]];
  isp_target_port u_isp_target_port (
    .clk(clk), .arst_n(arst_n), .bus(bus.device), .otpLoad(otpLoad),
    .otpAddr(otpAddr), .pinFuncSel(pinFuncSel), .hsMode(hsMode),
    .regRdAddr(regRdAddr), .regRdData(regRdData), .regWrStb(regWrStb),
    .regWrAddr(regWrAddr), .regWrData(regWrData), .busActive(busActive));
  // second target faces the bench itself, which can break the protocol
  isp_target_port u_isp_target_port_b (
    .clk(clk), .arst_n(arst_n), .bus(bus2.device), .otpLoad(1'h0),
    .otpAddr(isp_pkg::DEF_TARGET_ADDR), .pinFuncSel(3'h4), .hsMode(1'h0),
    .regRdAddr(8'h00), .regRdData(), .regWrStb(stbB),
    .regWrAddr(wAddrB), .regWrData(wDataB), .busActive());
  isp_bus_master u_isp_bus_master (
    .clk(clk), .arst_n(arst_n), .bus(bus.host), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdRead(cmdRead), .cmdTarget(cmdTarget),
    .cmdReg(cmdReg), .cmdLen(cmdLen), .wrByte(wrByte), .wrTaken(wrTaken),
    .rdValid(rdValid), .rdByte(rdByte), .done(done), .nackSeen(nackSeen));
  isp_bus_properties u_isp_bus_properties (
    .clk(clk), .arst_n(arst_n), .hostSclO(bus.hostSclO),
    .hostSclOe_n(bus.hostSclOe_n), .hostSdaO(bus.hostSdaO),
    .hostSdaOe_n(bus.hostSdaOe_n), .devSdaO(bus.devSdaO),
    .devSdaOe_n(bus.devSdaOe_n), .scl(bus.scl), .sda(bus.sda));
  always #(isp_pkg::CLK_PERIOD_NS / 2) clk = ~clk;
  always @(posedge bus.scl) begin
    shf = {shf[7:0], bus.sda};
    nb = nb + 1;
    if (nb == 9) begin
      wireQ.push_back(shf);
      nb = 0;
    end
  end
  // a start drops a part word, such as the scl rise of a repeated start
  always @(negedge bus.sda) begin
    if (bus.scl === 1'h1) nb = 0;
  end
  always @(posedge clk) begin
    if (regWrStb === 1'h1) wrQ.push_back({regWrAddr, regWrData});
    if (stbB === 1'h1) wrQB.push_back({wAddrB, wDataB});
    if (rdValid === 1'h1) rdQ.push_back(rdByte);
    if (wrTaken === 1'h1) #1 wrIdx = wrIdx + 1;
  end
  task automatic complete_run();
    if (fails == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic ea(input logic [7:0] b, input logic a);
    expQ.push_back({b, a});
  endtask
  task automatic cmp_wire();
    check("wire count", 16'(wireQ.size()), 16'(expQ.size()));
    foreach (expQ[i])
      check("wire", {7'h00, wireQ[i]}, {7'h00, expQ[i]});
  endtask
  task automatic run_cmd(input logic rd, input logic [6:0] t,
                         input logic [7:0] r, input logic [7:0] n);
    int k;
    wireQ = {};
    expQ = {};
    wrQ = {};
    rdQ = {};
    wrIdx = 0;
    k = 0;
    while (cmdReady !== 1'h1 && k < 100) begin
      @(posedge clk);
      #1 k++;
    end
    cmdValid = 1'h1;
    cmdRead = rd;
    cmdTarget = t;
    cmdReg = r;
    cmdLen = n;
    @(posedge clk);
    #1 cmdValid = 1'h0;
    k = 0;
    actSeen = 1'h0;
    while (done !== 1'h1 && k < 20000) begin
      @(posedge clk);
      #1 k++;
      actSeen = actSeen | busActive;
    end
    check("done", {15'h0000, done}, 16'h0001);
    check("idle after stop", {15'h0000, busActive}, 16'h0000);
  endtask
  task automatic t_write();
    wrBuf = '{8'hA5, 8'h3C, 8'h5A, 8'h00};
    run_cmd(1'h0, isp_pkg::DEF_TARGET_ADDR, 8'hFE, 8'h03);
    ea({isp_pkg::DEF_TARGET_ADDR, 1'h0}, 1'h0);
    ea(8'hFE, 1'h0);
    ea(8'hA5, 1'h0);
    ea(8'h3C, 1'h0);
    ea(8'h5A, 1'h0);
    cmp_wire();
    check("writes", 16'(wrQ.size()), 16'h0003);
    check("write 0", wrQ[0], 16'hFEA5);
    check("write 1", wrQ[1], 16'hFF3C);
    check("write 2", wrQ[2], 16'h005A);
    regRdAddr = 8'hFF;
    repeat (2) @(posedge clk);
    #1 check("peek", {8'h00, regRdData}, 16'h003C);
  endtask
  task automatic t_read();
    logic [7:0] ex [3] = '{8'hA5, 8'h3C, 8'h5A};
    run_cmd(1'h1, isp_pkg::DEF_TARGET_ADDR, 8'hFE, 8'h03);
    ea({isp_pkg::DEF_TARGET_ADDR, 1'h0}, 1'h0);
    ea(8'hFE, 1'h0);
    ea({isp_pkg::DEF_TARGET_ADDR, 1'h1}, 1'h0);
    foreach (ex[i]) ea(ex[i], i == 2);
    cmp_wire();
    check("reads", 16'(rdQ.size()), 16'h0003);
    foreach (ex[i]) check("read", {8'h00, rdQ[i]}, {8'h00, ex[i]});
  endtask
  task automatic t_addr();
    run_cmd(1'h0, 7'h2B, 8'h10, 8'h01);
    ea(8'h56, 1'h1);
    cmp_wire();
    check("foreign nack", {15'h0000, nackSeen}, 16'h0001);
    check("foreign writes", 16'(wrQ.size()), 16'h0000);
    otpAddr = 7'h2B;
    otpLoad = 1'h1;
    @(posedge clk);
    #1 otpLoad = 1'h0;
    wrBuf[0] = 8'h77;
    run_cmd(1'h0, 7'h2B, 8'h10, 8'h01);
    ea(8'h56, 1'h0);
    ea(8'h10, 1'h0);
    ea(8'h77, 1'h0);
    cmp_wire();
    check("new address write", wrQ[0], 16'h1077);
    otpAddr = isp_pkg::DEF_TARGET_ADDR;
    otpLoad = 1'h1;
    @(posedge clk);
    #1 otpLoad = 1'h0;
  endtask
  task automatic t_pins();
    logic ok;
    for (int c = 0; c < 8; c++) begin
      pinFuncSel = 3'(c);
      hsMode = pinFuncSel[0];
      ok = pinFuncSel inside {isp_pkg::PINSEL_GLOBAL_DVS,
                              isp_pkg::PINSEL_DVS_B12,
                              isp_pkg::PINSEL_DVS_B123};
      run_cmd(1'h0, isp_pkg::DEF_TARGET_ADDR, 8'h20, 8'h01);
      check("pin nack", {15'h0000, nackSeen}, {15'h0000, !ok});
      check("pin active", {15'h0000, actSeen}, {15'h0000, ok});
    end
    pinFuncSel = 3'h4;
    hsMode = 1'h0;
  endtask
  task automatic bb(input logic c, input logic d);
    @(posedge clk);
    #1 bus2.hostSclOe_n = c;
    bus2.hostSdaOe_n = d;
    repeat (60) @(posedge clk);
  endtask
  // g puts a 30 ns low spike on scl in the high half of bit 4
  task automatic bb_byte(input logic [7:0] b, input int n, input logic g);
    for (int i = 7; i > 7 - n; i--) begin
      bb(1'h0, b[i]);
      bb(1'h1, b[i]);
      if (g && i == 4) begin
        #1 bus2.hostSclOe_n = 1'h0;
        repeat (3) @(posedge clk);
        #1 bus2.hostSclOe_n = 1'h1;
        repeat (60) @(posedge clk);
      end
      bb(1'h0, b[i]);
    end
    if (n == 8) begin
      bb(1'h0, 1'h1);
      bb(1'h1, 1'h1);
      ackB = bus2.sda;
      bb(1'h0, 1'h1);
    end
  endtask
  task automatic t_partial();
    bb(1'h1, 1'h1);
    bb(1'h1, 1'h0);
    bb(1'h0, 1'h0);
    bb_byte({isp_pkg::DEF_TARGET_ADDR, 1'h0}, 8, 1'h0);
    check("ack b", {15'h0000, ackB}, 16'h0000);
    bb_byte(8'h40, 8, 1'h1);
    bb_byte(8'h96, 8, 1'h0);
    bb_byte(8'hC3, 4, 1'h0);
    bb(1'h0, 1'h0);
    bb(1'h1, 1'h0);
    bb(1'h1, 1'h1);
    repeat (20) @(posedge clk);
    check("b writes", 16'(wrQB.size()), 16'h0001);
    check("b write", wrQB[0], 16'h4096);
  endtask
  initial begin
    bus2.hostSclO = 1'h0;
    bus2.hostSdaO = 1'h0;
    bus2.hostSclOe_n = 1'h1;
    bus2.hostSdaOe_n = 1'h1;
    repeat (3) @(posedge clk);
    #1 arst_n = 1'h1;
    t_write();
    t_read();
    t_addr();
    t_pins();
    t_partial();
    complete_run();
  end
  initial begin
    repeat (95000) @(posedge clk);
    fails++;
    complete_run();
  end
endmodule
